// *** verilog/acs_sequencer.sv ***
// conversion sequencer: mode, result, interrupt registers and the sar control machine
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`include "acs_consts.svh"
module acs_sequencer #(
    parameter int RES_W = 8,
    parameter int CH_NUM = 8
) (
    input wire logic clock, // 10 MHz system clock
    input wire logic rst_n, // asynchronous reset, active low
    input wire logic [`ACS_ADDR_W-1:0] regAddr, // register address
    input wire logic [7:0] regWdata, // write data
    input wire logic regWr, // write strobe
    input wire logic regRd, // read strobe
    output logic [7:0] regRdata, // read data, cycle after strobe
    input wire logic hardwareTriggerPin, // hardware start trigger
    input wire logic compHigh, // analog comparator result
    output logic [$clog2(CH_NUM)-1:0] channelSel, // analog input multiplexer select
    output logic [RES_W-1:0] ladderCode, // trial code to the ladder
    output logic sampleHold, // sample switch closed
    output logic conversionDoneInterrupt, // level interrupt request
    output logic [1:0] irqPriority // priority of this source
);
    import acs_pkg::*;

    // the sar control and the register layout serve one 8-bit result and eight inputs only
    if (RES_W != 8) begin : gBadWidth
        $error("acs_sequencer serves an 8-bit result only");
    end
    if (CH_NUM != 8) begin : gBadChannels
        $error("acs_sequencer serves eight channels only");
    end

    // reset leaves through two flops so every register wakes on the same edge
    logic rstMeta_n, rstSync_n;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_n <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstMeta_n <= 1'b1;
            rstSync_n <= rstMeta_n;
        end
    end

    acs_state_t state_reg, state_next;
    logic [7:0] converterModeRegister_reg;
    logic [7:0] conversionResultRegister_reg;
    logic [7:0] converterInterruptControl_reg;
    logic [7:0] status_reg, mask_reg;
    logic [7:0] sampleCnt_reg;
    logic trigPrev_reg;
    logic [RES_W-1:0] trial;
    logic sarLast;

    wire logic wrMode = regWr && regAddr == `ACS_OFF_MODE;
    wire logic wrIrqCtl = regWr && regAddr == `ACS_OFF_IRQCTL;
    wire logic wrStatus = regWr && regAddr == `ACS_OFF_STATUS;
    wire logic wrMask = regWr && regAddr == `ACS_OFF_MASK;
    wire logic swStart = converterModeRegister_reg[`ACS_MODE_START];
    wire logic hwSelect = converterModeRegister_reg[`ACS_MODE_HWSEL];
    // the pin idles low, so the detector starts low after reset and sees no false edge
    wire logic trigEdge = hardwareTriggerPin && !trigPrev_reg;
    wire logic hwGo = hwSelect && trigEdge;
    wire logic swGo = !hwSelect && swStart;
    wire logic goNow = hwGo || swGo;
    wire logic sampleEnd = sampleCnt_reg == `ACS_SAMPLE_CYCLES - 8'h01;
    wire logic convDone = state_reg == ACS_APPROX && sarLast;
    wire logic [RES_W-1:0] finalCode = compHigh ? trial : (trial & ~{{(RES_W-1){1'b0}}, 1'b1});
    wire logic sarLoad = state_reg == ACS_SAMPLE && sampleEnd;
    wire logic sarStep = state_reg == ACS_APPROX;
    wire logic irqFlag = converterInterruptControl_reg[`ACS_IRQCTL_FLAG];
    wire logic irqMasked = converterInterruptControl_reg[`ACS_IRQCTL_MASK];
    wire logic irqPending = (irqFlag && !irqMasked) || |(status_reg & ~mask_reg);
    wire logic [7:0] statusNext = (status_reg & ~({8{wrStatus}} & regWdata)) | {7'h00, convDone};
    wire logic [7:0] irqCtlWr = wrIrqCtl ? regWdata : converterInterruptControl_reg;
    // a done event in the same cycle as a software clear leaves the flag set
    wire logic [7:0] irqCtlNext = convDone ? (irqCtlWr | (8'h01 << `ACS_IRQCTL_FLAG)) : irqCtlWr;

    logic [7:0] rdMux;
    always_comb begin
        case (regAddr)
            `ACS_OFF_MODE: rdMux = converterModeRegister_reg;
            `ACS_OFF_RESULT: rdMux = conversionResultRegister_reg;
            `ACS_OFF_IRQCTL: rdMux = converterInterruptControl_reg;
            `ACS_OFF_STATUS: rdMux = status_reg;
            `ACS_OFF_MASK: rdMux = mask_reg;
            default: rdMux = 8'h00;
        endcase
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ACS_IDLE: if (goNow) state_next = ACS_SAMPLE;
            ACS_SAMPLE: if (sampleEnd) state_next = ACS_APPROX;
            ACS_APPROX: if (sarLast) state_next = ACS_DONE;
            ACS_DONE: state_next = swGo ? ACS_SAMPLE : ACS_IDLE;
            default: state_next = ACS_IDLE;
        endcase
    end

    acs_sar_step #(.RES_W(RES_W)) sar (
        .clock(clock),
        .rstSync_n(rstSync_n),
        .load(sarLoad),
        .step(sarStep),
        .compHigh(compHigh),
        .trial(trial),
        .last(sarLast)
    );

    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state_reg <= ACS_IDLE;
            sampleCnt_reg <= 8'h00;
            trigPrev_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            sampleCnt_reg <= state_reg == ACS_SAMPLE ? sampleCnt_reg + 8'h01 : 8'h00;
            trigPrev_reg <= hardwareTriggerPin;
        end
    end

    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            converterModeRegister_reg <= `ACS_MODE_RESET;
            conversionResultRegister_reg <= 8'h00;
            converterInterruptControl_reg <= `ACS_IRQCTL_RESET;
            status_reg <= 8'h00;
            mask_reg <= `ACS_MASK_RESET;
        end else begin
            if (wrMode) converterModeRegister_reg <= regWdata;
            if (convDone) conversionResultRegister_reg <= finalCode;
            converterInterruptControl_reg <= irqCtlNext;
            status_reg <= statusNext;
            if (wrMask) mask_reg <= regWdata;
        end
    end

    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            regRdata <= 8'h00;
            channelSel <= '0;
            ladderCode <= '0;
            sampleHold <= 1'b0;
            conversionDoneInterrupt <= 1'b0;
            irqPriority <= 2'h3;
        end else begin
            regRdata <= regRd ? rdMux : 8'h00;
            channelSel <= converterModeRegister_reg[`ACS_MODE_CH_LO +: 3];
            ladderCode <= trial;
            sampleHold <= state_next == ACS_SAMPLE;
            conversionDoneInterrupt <= irqPending;
            irqPriority <= converterInterruptControl_reg[`ACS_IRQCTL_PRIO_LO +: 2];
        end
    end

    // conversion, register and interrupt checks
    sequence s_hwDone;
        convDone && hwSelect;
    endsequence
    a_hw_single_stop: assert property (@(posedge clock) disable iff (!rstSync_n)
        s_hwDone ##1 1'b1 |=> state_reg == ACS_IDLE)
        else $error("hardware conversion did not stop");
    a_hw_edge_start: assert property (@(posedge clock) disable iff (!rstSync_n)
        state_reg == ACS_IDLE && hwGo |=> state_reg == ACS_SAMPLE)
        else $error("trigger edge did not start");
    a_sw_start: assert property (@(posedge clock) disable iff (!rstSync_n)
        state_reg == ACS_IDLE && swGo |=> state_reg == ACS_SAMPLE)
        else $error("software start ignored");
    a_sw_repeat: assert property (@(posedge clock) disable iff (!rstSync_n)
        state_reg == ACS_DONE && swGo |=> state_reg == ACS_SAMPLE)
        else $error("software mode did not repeat");
    a_done_flag: assert property (@(posedge clock) disable iff (!rstSync_n)
        convDone |=> status_reg[0] && irqFlag)
        else $error("done did not set flags");
    a_result_hold: assert property (@(posedge clock) disable iff (!rstSync_n)
        !convDone |=> $stable(conversionResultRegister_reg))
        else $error("result changed mid conversion");
    a_conv_length: assert property (@(posedge clock) disable iff (!rstSync_n)
        sarLoad |=> (state_reg == ACS_APPROX) [*7] ##1 convDone)
        else $error("conversion not eight steps");
    a_irq_masked: assert property (@(posedge clock) disable iff (!rstSync_n)
        irqMasked && status_reg == 8'h00 |=> !conversionDoneInterrupt)
        else $error("masked request raised interrupt");
    a_channel: assert property (@(posedge clock) disable iff (!rstSync_n)
        ##1 channelSel == $past(converterModeRegister_reg[`ACS_MODE_CH_LO +: 3]))
        else $error("channel select mismatch");

    sequence s_convStart;
        state_reg == ACS_IDLE && goNow;
    endsequence
    sequence s_sampling;
        (state_reg == ACS_SAMPLE && sampleHold) [*4] ##1 state_reg == ACS_APPROX;
    endsequence

    a_sample_len: assert property (@(posedge clock) disable iff (!rstSync_n)
        s_convStart |=> s_sampling)
        else $error("sample phase was not four cycles");
    a_msb_first: assert property (@(posedge clock) disable iff (!rstSync_n)
        sarLoad |=> trial == {1'b1, {(RES_W-1){1'b0}}})
        else $error("approximation did not begin at the msb");
    a_no_start: assert property (@(posedge clock) disable iff (!rstSync_n)
        state_reg == ACS_IDLE && !goNow |=> state_reg == ACS_IDLE)
        else $error("conversion began without a start");
    a_hold_off: assert property (@(posedge clock) disable iff (!rstSync_n)
        state_reg == ACS_APPROX |-> !sampleHold)
        else $error("sample switch closed during approximation");
    a_irq_status: assert property (@(posedge clock) disable iff (!rstSync_n)
        (|(status_reg & ~mask_reg)) |=> conversionDoneInterrupt)
        else $error("unmasked status did not raise the interrupt");
    a_result_read: assert property (@(posedge clock) disable iff (!rstSync_n)
        regRd && regAddr == `ACS_OFF_RESULT |=> regRdata == $past(conversionResultRegister_reg))
        else $error("result read returned other data");
endmodule

// *** verilog/acs_consts.svh ***
// register offsets, field positions, reset values and timing counts of the conversion sequencer
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH
`define ACS_ADDR_W 4
`define ACS_OFF_MODE 4'h0
`define ACS_OFF_RESULT 4'h1
`define ACS_OFF_IRQCTL 4'h2
`define ACS_OFF_STATUS 4'h3
`define ACS_OFF_MASK 4'h4
`define ACS_MODE_START 0
`define ACS_MODE_HWSEL 1
`define ACS_MODE_CH_LO 2
`define ACS_MODE_RESET 8'h00
`define ACS_IRQCTL_FLAG 7
`define ACS_IRQCTL_MASK 6
`define ACS_IRQCTL_PRIO_LO 0
`define ACS_IRQCTL_RESET 8'h43
`define ACS_MASK_RESET 8'h00
`define ACS_SAMPLE_CYCLES 8'h04
`endif

// *** verilog/acs_pkg.sv ***
// types of the conversion sequencer
package acs_pkg;
    typedef enum logic [3:0] {
        ACS_IDLE = 4'b0001,
        ACS_SAMPLE = 4'b0010,
        ACS_APPROX = 4'b0100,
        ACS_DONE = 4'b1000
    } acs_state_t;
endpackage

// *** verilog/acs_sar_step.sv ***
// one successive-approximation engine: trial code, bit pointer and decided result
`timescale 1ns/10ps
module acs_sar_step #(
    parameter int RES_W = 8
) (
    input wire logic clock, // system clock
    input wire logic rstSync_n, // synchronised reset, active low
    input wire logic load, // begin a new approximation
    input wire logic step, // decide the current bit
    input wire logic compHigh, // comparator: input at or above trial
    output logic [RES_W-1:0] trial, // trial code to the ladder
    output logic last // current bit is the lsb
);
    logic [RES_W-1:0] bitReg;
    logic [RES_W-1:0] trialReg;
    wire logic [RES_W-1:0] keptBits = compHigh ? trialReg : (trialReg & ~bitReg);
    wire logic [RES_W-1:0] nextBit = bitReg >> 1;
    assign trial = trialReg;
    assign last = bitReg[0];
    if (RES_W < 2) begin : gBadWidth
        $error("acs_sar_step needs RES_W of at least 2");
    end
    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            bitReg <= '0;
            trialReg <= '0;
        end else if (load) begin
            bitReg <= {1'b1, {(RES_W-1){1'b0}}};
            trialReg <= {1'b1, {(RES_W-1){1'b0}}};
        end else if (step) begin
            bitReg <= nextBit;
            trialReg <= keptBits | nextBit;
        end
    end
endmodule

// *** dv/acs_analog_model.sv ***
// analog source model: eight channel levels and an ideal comparator that tracks the trial code
`timescale 1ns/10ps
module acs_analog_model (
    input wire logic clock, // system clock
    input wire logic [63:0] levels, // channel levels, channel 0 in the low byte
    input wire logic [2:0] channelSel, // selected channel
    input wire logic sampleHold, // sample phase
    output logic compHigh // level at or above trial
);
    logic [7:0] trialReg = 8'h00;
    logic [7:0] bitReg = 8'h00;
    logic toggle = 1'b0;
    logic [7:0] level;
    assign level = levels[channelSel*8 +: 8];
    // outside approximation the answer is meaningless, so it keeps changing
    assign compHigh = (bitReg != 8'h00) ? (level >= trialReg) : toggle;
    always_ff @(posedge clock) begin
        toggle <= ~toggle;
        if (sampleHold) begin
            trialReg <= 8'h80;
            bitReg <= 8'h80;
        end else if (bitReg != 8'h00) begin
            trialReg <= (compHigh ? trialReg : (trialReg & ~bitReg)) | (bitReg >> 1);
            bitReg <= bitReg >> 1;
        end
    end
endmodule

// *** dv/tb_top.sv ***
// testbench of the conversion sequencer
`timescale 1ns/10ps
module tb_top;
    logic clock, rst_n, regWr, regRd, hardwareTriggerPin, compHigh, sampleHold, irq;
    logic [3:0] regAddr;
    logic [7:0] regWdata, regRdata, ladderCode, rd;
    logic [2:0] channelSel;
    logic [1:0] irqPriority;
    logic [63:0] levels;
    int err_total = 0;
    int total_checks = 0;
    acs_sequencer acs_sequencer_inst (.clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .hardwareTriggerPin(hardwareTriggerPin),
        .compHigh(compHigh), .channelSel(channelSel), .ladderCode(ladderCode), .sampleHold(sampleHold),
        .conversionDoneInterrupt(irq), .irqPriority(irqPriority));
    acs_analog_model acs_analog_model_inst (.clock(clock), .levels(levels), .channelSel(channelSel),
        .sampleHold(sampleHold), .compHigh(compHigh));
    task automatic check(logic [7:0] got, logic [7:0] exp, string what);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clock);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clock);
        regWr <= 1'b0;
    endtask
    task automatic rdReg(logic [3:0] a);
        @(posedge clock);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRd <= 1'b0;
        #1;
        rd = regRdata;
    endtask
    task automatic waitIrq(logic lvl);
        int n;
        n = 0;
        #1;
        while (irq !== lvl && n < 40) begin
            @(posedge clock);
            #1;
            n++;
        end
        check({7'h00, irq}, {7'h00, lvl}, "interrupt level");
    endtask
    task automatic clearFlags;
        wr(4'h3, 8'h01);
        wr(4'h2, 8'h03);
    endtask
    task automatic t_reset;
        rdReg(4'h2);
        check(rd, 8'h43, "control reset");
        check({6'h00, irqPriority}, 8'h03, "priority output");
        rdReg(4'h0);
        check(rd, 8'h00, "mode reset");
        rdReg(4'h5);
        check(rd, 8'h00, "unmapped read");
    endtask
    task automatic t_soft;
        levels[47:40] = 8'ha5;
        wr(4'h0, 8'h15);
        waitIrq(1'b1);
        levels[47:40] = 8'h3c;
        check({5'h00, channelSel}, 8'h05, "channel select");
        rdReg(4'h1);
        check(rd, 8'ha5, "first result");
        clearFlags();
        waitIrq(1'b0);
        waitIrq(1'b1);
        rdReg(4'h1);
        check(rd, 8'h3c, "repeated result");
        wr(4'h0, 8'h00);
        repeat (20) @(posedge clock);
        clearFlags();
        repeat (40) @(posedge clock);
        #1;
        check({7'h00, irq}, 8'h00, "stopped");
    endtask
    task automatic t_mask;
        wr(4'h4, 8'h01);
        wr(4'h2, 8'h43);
        wr(4'h0, 8'h01);
        repeat (20) @(posedge clock);
        wr(4'h0, 8'h00);
        repeat (20) @(posedge clock);
        #1;
        check({7'h00, irq}, 8'h00, "masked");
        rdReg(4'h3);
        check(rd, 8'h01, "status set");
        rdReg(4'h2);
        check(rd, 8'hc3, "control flag");
        wr(4'h2, 8'h03);
        repeat (3) @(posedge clock);
        #1;
        check({7'h00, irq}, 8'h00, "flag cleared");
        wr(4'h4, 8'h00);
        waitIrq(1'b1);
        wr(4'h3, 8'h01);
        waitIrq(1'b0);
    endtask
    task automatic t_hw;
        levels[23:16] = 8'h5a;
        wr(4'h0, 8'h0a);
        wr(4'h2, 8'h01);
        repeat (20) @(posedge clock);
        #1;
        check({7'h00, irq}, 8'h00, "no trigger");
        check({6'h00, irqPriority}, 8'h01, "priority field");
        @(posedge clock);
        hardwareTriggerPin <= 1'b1;
        @(posedge clock);
        hardwareTriggerPin <= 1'b0;
        #1;
        check({7'h00, sampleHold}, 8'h01, "sampling started");
        waitIrq(1'b1);
        rdReg(4'h1);
        check(rd, 8'h5a, "hardware result");
        clearFlags();
        repeat (40) @(posedge clock);
        #1;
        check({7'h00, irq}, 8'h00, "single shot");
        check(ladderCode, 8'h5a, "final trial code");
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial begin
        #(100 * 3000);
        err_total++;
        stop_test();
    end
    initial begin
        {rst_n, regWr, regRd, hardwareTriggerPin, regAddr, regWdata} = '0;
        levels = 64'h7766554433221100;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        t_reset();
        $display("reset test done");
        t_soft();
        $display("software start test done");
        t_mask();
        $display("mask test done");
        t_hw();
        $display("hardware start test done");
        stop_test();
    end
endmodule
